// >>> iol_pkg.sv
package iol_pkg;

  // Storage sizes and buffering
  localparam int IOL_FIFO_DEPTH = 4;
  localparam int IOL_MEM_WORDS = 16;
  localparam int IOL_CSR_WORDS = 8;

  // Value is arbitrary; low bits carry the word index
  localparam logic [31:0] IOL_CAP_ID = 32'h5a5a_0000;
  localparam logic [31:0] IOL_CSR_RESET = 32'h0000_0000;

  // Byte counts and limits
  localparam logic [3:0] IOL_BYTE = 4'h1;
  localparam logic [3:0] IOL_HALF = 4'h2;
  localparam logic [3:0] IOL_WORD = 4'h4;
  localparam logic [7:0] IOL_LANES_ALL = 8'hff;
  localparam logic [5:0] IOL_ONE_BEAT = 6'h01;
  localparam logic [5:0] IOL_MAINT_MAX_BEATS = 6'h08;

  typedef enum logic [3:0] {
    K_RD = 4'b0000,
    K_PW = 4'b0001,
    K_AW = 4'b0010,
    K_SW = 4'b0011,
    K_INC = 4'b0100,
    K_DEC = 4'b0101,
    K_TSW = 4'b0110,
    K_SET = 4'b0111,
    K_CLR = 4'b1000,
    K_MRD = 4'b1001,
    K_MWR = 4'b1010
  } iol_kind_type;

  typedef enum logic [1:0] {
    R_DONE = 2'b00,
    R_ERROR = 2'b01,
    R_MDONE = 2'b10,
    R_MERROR = 2'b11
  } iol_rsp_kind_type;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_READ = 3'b001,
    S_WRITE = 3'b010,
    S_ATOM_WB = 3'b011,
    S_STATUS = 3'b100,
    S_DRAIN = 3'b101
  } iol_state_type;

  typedef struct packed {
    iol_kind_type kind;
    logic [7:0] tid;
    logic [28:0] addr;
    logic wdptr;
    logic [3:0] size;
    logic sop;
    logic eop;
    logic [63:0] data;
  } iol_req_type;

  typedef struct packed {
    iol_rsp_kind_type kind;
    logic [7:0] tid;
    logic sop;
    logic eop;
    logic [63:0] data;
  } iol_rsp_type;

  function automatic logic [63:0] iol_swap(input logic [63:0] d);
    logic [63:0] r;
    r = d;
    for (int i = 0; i < 8; i++) r[8*i +: 8] = d[8*(7-i) +: 8];
    return r;
  endfunction : iol_swap

  function automatic logic [63:0] iol_expand(input logic [7:0] m);
    logic [63:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) r[8*i +: 8] = {8{m[i]}};
    return r;
  endfunction : iol_expand

  function automatic logic [3:0] iol_ones(input logic [7:0] m);
    logic [3:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) r = r + 4'(m[i]);
    return r;
  endfunction : iol_ones

  function automatic logic [2:0] iol_tzero(input logic [7:0] m);
    logic [2:0] r;
    r = '0;
    for (int i = 7; i >= 0; i--) if (m[i]) r = 3'(i);
    return r;
  endfunction : iol_tzero

endpackage : iol_pkg

// >>> iol_fifo.sv
`timescale 1ns/1ps
module iol_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = store[rd_ptr];
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  // Flags kept as flops so ready reaches the pins without logic
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      count <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      count <= next_count;
      in_ready <= next_count != (AW+1)'(DEPTH);
      out_valid <= next_count != '0;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + AW'(1);
      if (pop) rd_ptr <= rd_ptr + AW'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (push) store[wr_ptr] <= in_data;
  end

endmodule : iol_fifo

// >>> iol_lane_decode.sv
`timescale 1ns/1ps
module iol_lane_decode (
  // Size fields of a request
  input wire logic wdptr,
  input wire logic [3:0] size,
  input wire logic is_write,
  // Decoded shape
  output logic [7:0] mask,
  output logic [5:0] beats,
  output logic multi,
  output logic reserved
);
  assign multi = beats != iol_pkg::IOL_ONE_BEAT;

  always_comb begin
    mask = iol_pkg::IOL_LANES_ALL;
    beats = iol_pkg::IOL_ONE_BEAT;
    reserved = 1'b0;
    casez ({wdptr, size})
      5'b0_00??: mask = 8'h80 >> size[1:0];
      5'b1_00??: mask = 8'h08 >> size[1:0];
      5'b0_0100: mask = 8'hc0;
      5'b0_0101: mask = 8'he0;
      5'b0_0110: mask = 8'h30;
      5'b0_0111: mask = 8'hf8;
      5'b1_0100: mask = 8'h0c;
      5'b1_0101: mask = 8'h07;
      5'b1_0110: mask = 8'h03;
      5'b1_0111: mask = 8'h1f;
      5'b0_1000: mask = 8'hf0;
      5'b1_1000: mask = 8'h0f;
      5'b0_1001: mask = 8'hfc;
      5'b1_1001: mask = 8'h3f;
      5'b0_1010: mask = 8'hfe;
      5'b1_1010: mask = 8'h7f;
      5'b1_1011: beats = 6'h02;
      5'b0_1100: beats = 6'h04;
      5'b1_1100: beats = 6'h08;
      5'b0_1101: begin
        beats = 6'h0c;
        reserved = is_write;
      end
      5'b1_1101: beats = 6'h10;
      5'b0_1110: begin
        beats = 6'h14;
        reserved = is_write;
      end
      5'b1_1110: begin
        beats = 6'h18;
        reserved = is_write;
      end
      5'b0_1111: begin
        beats = 6'h1c;
        reserved = is_write;
      end
      5'b1_1111: beats = 6'h20;
      default: mask = iol_pkg::IOL_LANES_ALL;
    endcase
  end

endmodule : iol_lane_decode

// >>> iol_target.sv
`timescale 1ns/1ps
module iol_target (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Request beats from the fabric
  input wire logic req_valid,
  output logic req_ready,
  input wire iol_pkg::iol_req_type req,
  // Response beats to the fabric
  output logic rsp_valid,
  input wire logic rsp_ready,
  output iol_pkg::iol_rsp_type rsp
);
  iol_pkg::iol_req_type q;
  iol_pkg::iol_req_type hdr;
  iol_pkg::iol_rsp_type next_rsp;
  iol_pkg::iol_state_type state;
  logic q_valid;
  logic q_ready;
  logic [7:0] dec_mask;
  logic [5:0] dec_beats;
  logic dec_multi;
  logic dec_rsvd;
  logic [7:0] hdr_mask;
  logic [5:0] hdr_beats;
  logic hdr_maint;
  logic hdr_err;
  logic hdr_rep;
  logic [5:0] cnt;
  logic [63:0] mem [iol_pkg::IOL_MEM_WORDS];
  logic [31:0] csr [iol_pkg::IOL_CSR_WORDS];

  // Input buffer; a stalled response path backs up into it
  iol_fifo #(
    .WIDTH($bits(iol_pkg::iol_req_type)),
    .DEPTH(iol_pkg::IOL_FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .reset(reset),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data(req),
    .out_valid(q_valid),
    .out_ready(q_ready),
    .out_data(q)
  );

  // Request classification
  logic k_rd, k_pw, k_aw, k_sw, k_at, k_mr, k_mw, k_known, bad, take, slot_free, rsp_load;
  logic at_ok, mt_ok, hdr_at;
  logic [3:0] nb;
  assign k_rd = q.kind == iol_pkg::K_RD;
  assign k_pw = q.kind == iol_pkg::K_PW;
  assign k_aw = q.kind == iol_pkg::K_AW;
  assign k_sw = q.kind == iol_pkg::K_SW;
  assign k_mr = q.kind == iol_pkg::K_MRD;
  assign k_mw = q.kind == iol_pkg::K_MWR;
  assign k_at = q.kind inside {iol_pkg::K_INC, iol_pkg::K_DEC, iol_pkg::K_TSW,
                               iol_pkg::K_SET, iol_pkg::K_CLR};
  assign k_known = k_rd || k_pw || k_aw || k_sw || k_at || k_mr || k_mw;
  assign hdr_at = hdr.kind inside {iol_pkg::K_INC, iol_pkg::K_DEC, iol_pkg::K_TSW,
                                   iol_pkg::K_SET, iol_pkg::K_CLR};

  iol_lane_decode u_lanes (
    .wdptr(q.wdptr),
    .size(q.size),
    .is_write(!(k_rd || k_mr)),
    .mask(dec_mask),
    .beats(dec_beats),
    .multi(dec_multi),
    .reserved(dec_rsvd)
  );

  assign nb = iol_pkg::iol_ones(dec_mask);
  assign at_ok = !dec_multi && nb inside {iol_pkg::IOL_BYTE, iol_pkg::IOL_HALF,
                                          iol_pkg::IOL_WORD};
  assign mt_ok = dec_multi ? dec_beats <= iol_pkg::IOL_MAINT_MAX_BEATS
                           : (nb == iol_pkg::IOL_WORD
                              || dec_mask == iol_pkg::IOL_LANES_ALL);
  assign bad = !k_known || ((k_pw || k_aw || k_mw) && dec_rsvd) || (k_at && !at_ok)
               || ((k_mr || k_mw) && !mt_ok);
  assign take = state == iol_pkg::S_IDLE && q_valid && q.sop;
  assign slot_free = !rsp_valid || rsp_ready;
  assign q_ready = state inside {iol_pkg::S_IDLE, iol_pkg::S_WRITE, iol_pkg::S_DRAIN};

  // Header capture
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      hdr <= '0;
      hdr_mask <= '0;
      hdr_beats <= '0;
      hdr_maint <= 1'b0;
      hdr_err <= 1'b0;
      hdr_rep <= 1'b0;
    end else if (take) begin
      hdr <= q;
      hdr_mask <= k_sw ? iol_pkg::IOL_LANES_ALL : dec_mask;
      hdr_beats <= dec_beats;
      hdr_maint <= k_mr || k_mw;
      hdr_err <= bad;
      hdr_rep <= !(k_pw || k_sw);
    end
  end

  // Sequencer; one request at a time keeps atomics indivisible
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state <= iol_pkg::S_IDLE;
      cnt <= '0;
    end else begin
      unique case (state)
        iol_pkg::S_IDLE: if (take) begin
          cnt <= iol_pkg::IOL_ONE_BEAT;
          if (bad) begin
            state <= !q.eop ? iol_pkg::S_DRAIN
                   : (!(k_pw || k_sw) ? iol_pkg::S_STATUS : iol_pkg::S_IDLE);
          end else if (k_rd || k_mr || k_at) begin
            state <= iol_pkg::S_READ;
            cnt <= '0;
          end else if (!q.eop) begin
            state <= iol_pkg::S_WRITE;
          end else begin
            state <= (k_aw || k_mw) ? iol_pkg::S_STATUS : iol_pkg::S_IDLE;
          end
        end
        iol_pkg::S_READ: if (slot_free) begin
          cnt <= cnt + 6'h01;
          if (cnt + 6'h01 == hdr_beats) begin
            state <= hdr_at ? iol_pkg::S_ATOM_WB : iol_pkg::S_IDLE;
          end
        end
        iol_pkg::S_WRITE: if (q_valid) begin
          cnt <= cnt + 6'h01;
          if (q.eop) state <= hdr_rep ? iol_pkg::S_STATUS : iol_pkg::S_IDLE;
        end
        iol_pkg::S_ATOM_WB: state <= iol_pkg::S_IDLE;
        iol_pkg::S_STATUS: if (slot_free) state <= iol_pkg::S_IDLE;
        iol_pkg::S_DRAIN: if (q_valid && q.eop) begin
          state <= hdr_rep ? iol_pkg::S_STATUS : iol_pkg::S_IDLE;
        end
        default: state <= iol_pkg::S_IDLE;
      endcase
    end
  end

  // Atomic arithmetic on the addressed lanes, in link byte order
  logic [63:0] at_old, at_m, at_f, at_nf, at_new;
  logic [5:0] sh;
  always_comb begin
    at_old = iol_pkg::iol_swap(mem[hdr.addr[3:0]]);
    at_m = iol_pkg::iol_expand(hdr_mask);
    sh = {iol_pkg::iol_tzero(hdr_mask), 3'b000};
    at_f = (at_old & at_m) >> sh;
    unique case (hdr.kind)
      iol_pkg::K_INC: at_nf = at_f + 64'h0000_0000_0000_0001;
      iol_pkg::K_DEC: at_nf = at_f - 64'h0000_0000_0000_0001;
      iol_pkg::K_SET: at_nf = '1;
      iol_pkg::K_CLR: at_nf = '0;
      iol_pkg::K_TSW: at_nf = (at_f == '0) ? ((hdr.data & at_m) >> sh) : at_f;
      default: at_nf = at_f;
    endcase
    at_new = (at_old & ~at_m) | ((at_nf << sh) & at_m);
  end

  // Write port for memory and configuration space
  logic mem_we, cfg_we;
  logic [3:0] mem_idx;
  logic [7:0] mem_msk;
  logic [63:0] mem_wbe;
  always_comb begin
    mem_we = 1'b0;
    cfg_we = 1'b0;
    mem_idx = hdr.addr[3:0] + cnt[3:0];
    mem_msk = iol_pkg::IOL_LANES_ALL;
    mem_wbe = q.data;
    if (take && !bad && (k_pw || k_aw || k_sw || k_mw)) begin
      mem_we = !k_mw;
      cfg_we = k_mw;
      mem_idx = q.addr[3:0];
      mem_msk = (k_sw || dec_multi) ? iol_pkg::IOL_LANES_ALL : dec_mask;
    end else if (state == iol_pkg::S_WRITE && q_valid) begin
      mem_we = !hdr_maint;
      cfg_we = hdr_maint;
    end else if (state == iol_pkg::S_ATOM_WB) begin
      mem_we = 1'b1;
      mem_idx = hdr.addr[3:0];
      mem_wbe = at_new;
    end
  end

  // Little-endian store behind a big-endian link
  always_ff @(posedge mclk) begin
    if (mem_we) begin
      mem[mem_idx] <= iol_pkg::iol_swap((iol_pkg::iol_swap(mem[mem_idx])
                      & ~iol_pkg::iol_expand(mem_msk))
                      | (mem_wbe & iol_pkg::iol_expand(mem_msk)));
    end
  end

  // Writable control words; capability words ignore writes
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < iol_pkg::IOL_CSR_WORDS; i++) csr[i] <= iol_pkg::IOL_CSR_RESET;
    end else if (cfg_we && mem_idx[2]) begin
      for (int h = 0; h < 2; h++) begin
        if (|mem_msk[7-4*h -: 4]) csr[{mem_idx[1:0], 1'(h)}] <= mem_wbe[63-32*h -: 32];
      end
    end
  end

  // Read beat and response builder
  logic [2:0] cn;
  logic [63:0] rd_be;
  always_comb begin
    cn = hdr.addr[2:0] + cnt[2:0];
    if (!hdr_maint) begin
      rd_be = iol_pkg::iol_swap(mem[mem_idx]);
    end else if (cn[2]) begin
      rd_be = {csr[{cn[1:0], 1'b0}], csr[{cn[1:0], 1'b1}]};
    end else begin
      rd_be = {iol_pkg::IOL_CAP_ID | {28'h000_0000, cn, 1'b0},
               iol_pkg::IOL_CAP_ID | {28'h000_0000, cn, 1'b1}};
    end
    rsp_load = slot_free && (state == iol_pkg::S_READ || state == iol_pkg::S_STATUS);
    next_rsp.tid = hdr.tid;
    next_rsp.sop = state == iol_pkg::S_STATUS || cnt == '0;
    next_rsp.eop = state == iol_pkg::S_STATUS || cnt + 6'h01 == hdr_beats;
    next_rsp.data = '0;
    if (state == iol_pkg::S_READ) begin
      next_rsp.data = rd_be & iol_pkg::iol_expand(hdr_mask);
    end
    if (hdr_err) begin
      next_rsp.kind = hdr_maint ? iol_pkg::R_MERROR : iol_pkg::R_ERROR;
    end else begin
      next_rsp.kind = hdr_maint ? iol_pkg::R_MDONE : iol_pkg::R_DONE;
    end
  end

  // Registered response; holds until taken
  logic [63:0] rsp_m64;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rsp_valid <= 1'b0;
      rsp <= '0;
      rsp_m64 <= '0;
    end else if (rsp_load) begin
      rsp_valid <= 1'b1;
      rsp <= next_rsp;
      rsp_m64 <= (state == iol_pkg::S_READ) ? iol_pkg::iol_expand(hdr_mask) : '0;
    end else if (rsp_ready) begin
      rsp_valid <= 1'b0;
    end
  end

  // Checks
  logic [5:0] read_loads;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) read_loads <= '0;
    else if (state == iol_pkg::S_IDLE) read_loads <= '0;
    else if (rsp_load && state == iol_pkg::S_READ) read_loads <= read_loads + 6'h01;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_at_return;
    state == iol_pkg::S_READ && rsp_load && hdr_at;
  endsequence
  sequence s_at_bad;
    take && k_at && bad;
  endsequence
  sequence s_aw_done;
    (take && !bad && k_aw && q.eop) || (state == iol_pkg::S_WRITE && q_valid && q.eop
      && hdr.kind == iol_pkg::K_AW);
  endsequence

  a_read_length: assert property (state != iol_pkg::S_READ && $past(state) == iol_pkg::S_READ
    |-> read_loads == $past(hdr_beats)) else $error("read beat count wrong");
  a_pad_lanes: assert property (rsp_valid |-> (rsp.data & ~rsp_m64) == '0)
    else $error("unrequested lanes not zero");
  a_posted_silent: assert property (take && !bad && (k_pw || k_sw) && q.eop
    |=> state == iol_pkg::S_IDLE && !rsp_load) else $error("posted write answered");
  a_acked_reply: assert property (s_aw_done |-> mem_we ##1 state == iol_pkg::S_STATUS
    && (!rsp_load || next_rsp.kind == iol_pkg::R_DONE)) else $error("acked write reply");
  a_atomic_order: assert property (s_at_return |=> state == iol_pkg::S_ATOM_WB && mem_we
    ##1 state == iol_pkg::S_IDLE) else $error("atomic order broken");
  a_atomic_bad_size: assert property (s_at_bad |-> !mem_we ##1 !mem_we
    && state == iol_pkg::S_STATUS && hdr_err) else $error("bad atomic accepted");
  a_maint_kind: assert property (rsp_load && hdr_maint
    |-> next_rsp.kind inside {iol_pkg::R_MDONE, iol_pkg::R_MERROR})
    else $error("maintenance reply kind");
  a_stream_whole: assert property (take && k_sw |-> mem_msk == iol_pkg::IOL_LANES_ALL)
    else $error("stream write partial");
  a_endian_store: assert property (mem_we && mem_msk == iol_pkg::IOL_LANES_ALL
    |=> mem[$past(mem_idx)] == iol_pkg::iol_swap($past(mem_wbe)))
    else $error("byte order not converted");

endmodule : iol_target

// >>> iol_requester.sv
`timescale 1ns/1ps
module iol_requester (
  // Clock
  input wire logic mclk,
  // Request side
  output logic req_valid,
  input wire logic req_ready,
  output iol_pkg::iol_req_type req,
  // Response side
  input wire logic hold_rsp,
  input wire logic rsp_valid,
  output logic rsp_ready,
  input wire iol_pkg::iol_rsp_type rsp
);
  iol_pkg::iol_rsp_type got[$];

  initial begin
    req_valid = 1'h0;
    req = '0;
    rsp_ready = 1'h1;
  end

  // Kept in arrival order so ids can be matched before reuse
  always @(posedge mclk) begin
    if (rsp_valid && rsp_ready) begin
      got.push_back(rsp);
    end
  end

  always @(negedge mclk) begin
    rsp_ready <= !hold_rsp;
  end

  // Whole aligned beats only; callers split unaligned runs
  task automatic send_pkt(input iol_pkg::iol_req_type q[$]);
    foreach (q[i]) begin
      @(negedge mclk);
      req_valid = 1'h1;
      req = q[i];
      do @(posedge mclk); while (req_ready !== 1'h1);
    end
    // Released lines show the inverse, never a stale copy
    @(negedge mclk);
    req_valid = 1'h0;
    req = iol_pkg::iol_req_type'(~req);
  endtask : send_pkt
endmodule : iol_requester

// >>> tb.sv
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    iol_pkg::iol_req_type q;
    logic [1:0] has;
    iol_pkg::iol_rsp_kind_type k;
    logic [63:0] d;
  } iol_row_type;

  localparam logic [63:0] dw_a = 64'h0123_4567_89ab_cdef;
  localparam logic [63:0] dw_b = 64'h1111_2222_3333_4444;
  localparam logic [63:0] dw_c = 64'h5555_6666_7777_8888;

  logic mclk;
  logic reset;
  logic hold_rsp;
  logic req_valid;
  logic req_ready;
  logic rsp_valid;
  logic rsp_ready;
  iol_pkg::iol_req_type req;
  iol_pkg::iol_rsp_type rsp;
  iol_pkg::iol_rsp_type r;
  iol_pkg::iol_req_type pk[$];
  iol_row_type rows[$];
  int failures;
  int check_count;

  iol_target u_dut (
    .mclk(mclk), .reset(reset),
    .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp)
  );

  iol_requester u_req (
    .mclk(mclk), .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .hold_rsp(hold_rsp), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp)
  );

  initial mclk = 1'h0;
  always #5 mclk = ~mclk;

  function automatic iol_pkg::iol_req_type beat(iol_pkg::iol_kind_type k, logic [4:0] a,
      logic w, logic [3:0] s, logic [63:0] d, logic [7:0] t);
    beat = '{kind: k, tid: t, addr: 29'(a), wdptr: w, size: s, sop: 1'h1, eop: 1'h1, data: d};
  endfunction : beat

  task automatic add(iol_pkg::iol_kind_type k, logic [4:0] a, logic w, logic [3:0] s,
      logic [63:0] d, logic [1:0] h, iol_pkg::iol_rsp_kind_type rk, logic [63:0] e);
    rows.push_back('{beat(k, a, w, s, d, 8'(rows.size())), h, rk, e});
  endtask : add

  task automatic chk(string what, logic [63:0] e, logic [63:0] s);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", what, e, s);
    end
  endtask : chk

  task automatic take(output iol_pkg::iol_rsp_type t);
    int n;
    n = 0;
    t = '0;
    while (u_req.got.size() == 0 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    check_count++;
    if (u_req.got.size() == 0) begin
      failures++;
      $display("Error response expected 1 seen 0");
    end else begin
      t = u_req.got.pop_front();
    end
  endtask : take

  task automatic complete_run();
    $display("Checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  // Generous span: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge mclk);
    failures++;
    $display("Error watchdog expected done seen timeout");
    complete_run();
  end

  initial begin
    failures = 0;
    check_count = 0;
    reset = 1'h1;
    hold_rsp = 1'h0;
    add(iol_pkg::K_PW, 5'h2, 1'h0, 4'hb, dw_a, 2'h0, iol_pkg::R_DONE, 64'h0);
    add(iol_pkg::K_RD, 5'h2, 1'h0, 4'hb, 64'h0, 2'h3, iol_pkg::R_DONE, dw_a);
    add(iol_pkg::K_RD, 5'h12, 1'h0, 4'hb, 64'h0, 2'h3, iol_pkg::R_DONE, dw_a);
    add(iol_pkg::K_PW, 5'h3, 1'h0, 4'hb, 64'h0, 2'h0, iol_pkg::R_DONE, 64'h0);
    add(iol_pkg::K_PW, 5'h3, 1'h1, 4'h5, '1, 2'h0, iol_pkg::R_DONE, 64'h0);
    add(iol_pkg::K_RD, 5'h3, 1'h0, 4'hb, 64'h0, 2'h3, iol_pkg::R_DONE,
        64'h0000_0000_00ff_ffff);
    add(iol_pkg::K_RD, 5'h3, 1'h1, 4'h3, 64'h0, 2'h3, iol_pkg::R_DONE,
        64'h0000_0000_0000_00ff);
    add(iol_pkg::K_AW, 5'h4, 1'h0, 4'hb, dw_b, 2'h1, iol_pkg::R_DONE, 64'h0);
    add(iol_pkg::K_SW, 5'h5, 1'h0, 4'hb, dw_c, 2'h0, iol_pkg::R_DONE, 64'h0);
    add(iol_pkg::K_RD, 5'h5, 1'h0, 4'hb, 64'h0, 2'h3, iol_pkg::R_DONE, dw_c);
    add(iol_pkg::K_INC, 5'h4, 1'h1, 4'h8, 64'h0, 2'h3, iol_pkg::R_DONE,
        64'h0000_0000_3333_4444);
    add(iol_pkg::K_DEC, 5'h4, 1'h0, 4'h4, 64'h0, 2'h3, iol_pkg::R_DONE,
        64'h1111_0000_0000_0000);
    add(iol_pkg::K_SET, 5'h4, 1'h0, 4'h2, 64'h0, 2'h3, iol_pkg::R_DONE,
        64'h0000_2200_0000_0000);
    add(iol_pkg::K_CLR, 5'h4, 1'h0, 4'h6, 64'h0, 2'h3, iol_pkg::R_DONE,
        64'h0000_ff22_0000_0000);
    add(iol_pkg::K_TSW, 5'h4, 1'h0, 4'h6, 64'h0000_abcd_0000_0000, 2'h3, iol_pkg::R_DONE,
        64'h0);
    add(iol_pkg::K_TSW, 5'h4, 1'h0, 4'h8, 64'hdead_beef_0000_0000, 2'h3, iol_pkg::R_DONE,
        64'h1110_abcd_0000_0000);
    add(iol_pkg::K_INC, 5'h4, 1'h0, 4'hb, 64'h0, 2'h1, iol_pkg::R_ERROR, 64'h0);
    add(iol_pkg::K_RD, 5'h4, 1'h0, 4'hb, 64'h0, 2'h3, iol_pkg::R_DONE,
        64'h1110_abcd_3333_4445);
    add(iol_pkg::K_AW, 5'h6, 1'h0, 4'hd, dw_a, 2'h1, iol_pkg::R_ERROR, 64'h0);
    add(iol_pkg::K_MRD, 5'h0, 1'h0, 4'h8, 64'h0, 2'h3, iol_pkg::R_MDONE,
        {iol_pkg::IOL_CAP_ID, 32'h0});
    add(iol_pkg::K_MRD, 5'h1, 1'h1, 4'h8, 64'h0, 2'h3, iol_pkg::R_MDONE,
        {32'h0, iol_pkg::IOL_CAP_ID | 32'h0000_0003});
    add(iol_pkg::K_MWR, 5'h4, 1'h1, 4'h8, 64'h0000_0000_1234_5678, 2'h1, iol_pkg::R_MDONE,
        64'h0);
    add(iol_pkg::K_MRD, 5'h4, 1'h1, 4'h8, 64'h0, 2'h3, iol_pkg::R_MDONE,
        64'h0000_0000_1234_5678);
    add(iol_pkg::K_MRD, 5'h1, 1'h0, 4'h5, 64'h0, 2'h1, iol_pkg::R_MERROR, 64'h0);
    repeat (20) @(negedge mclk);
    reset = 1'h0;
    foreach (rows[i]) begin
      pk = {rows[i].q};
      u_req.send_pkt(pk);
      if (rows[i].has == 2'h0) begin
        repeat (8) @(posedge mclk);
        chk("silence", 64'h0, 64'(u_req.got.size()));
      end else begin
        take(r);
        chk("kind", 64'(rows[i].k), 64'(r.kind));
        chk("tid", 64'(rows[i].q.tid), 64'(r.tid));
        if (rows[i].has[1]) chk("data", rows[i].d, r.data);
      end
    end
    // Two-beat write, then a two-beat read with the far side stalling
    pk = {beat(iol_pkg::K_PW, 5'h8, 1'h1, 4'hb, dw_a, 8'h30),
          beat(iol_pkg::K_PW, 5'h9, 1'h1, 4'hb, dw_b, 8'h30)};
    pk[0].eop = 1'h0;
    pk[1].sop = 1'h0;
    u_req.send_pkt(pk);
    hold_rsp <= 1'h1;
    pk = {beat(iol_pkg::K_RD, 5'h8, 1'h1, 4'hb, 64'h0, 8'h31)};
    u_req.send_pkt(pk);
    repeat (6) @(negedge mclk);
    hold_rsp <= 1'h0;
    take(r);
    chk("beat0", dw_a, r.data);
    chk("frame0", 64'h2, 64'({r.sop, r.eop}));
    take(r);
    chk("beat1", dw_b, r.data);
    chk("frame1", 64'h1, 64'({r.sop, r.eop}));
    repeat (8) @(posedge mclk);
    chk("extra", 64'h0, 64'(u_req.got.size()));
    // Reserved-size acked write of two beats is drained and refused
    pk = {beat(iol_pkg::K_AW, 5'h8, 1'h0, 4'hd, dw_c, 8'h32),
          beat(iol_pkg::K_AW, 5'h9, 1'h0, 4'hd, dw_c, 8'h32)};
    pk[0].eop = 1'h0;
    pk[1].sop = 1'h0;
    u_req.send_pkt(pk);
    take(r);
    chk("drained kind", 64'(iol_pkg::R_ERROR), 64'(r.kind));
    chk("drained tid", 64'h32, 64'(r.tid));
    pk = {beat(iol_pkg::K_RD, 5'h9, 1'h0, 4'hb, 64'h0, 8'h33)};
    u_req.send_pkt(pk);
    take(r);
    chk("drained store", dw_b, r.data);
    // Fill the request buffer while responses are held back
    hold_rsp <= 1'h1;
    fork
      begin
        iol_pkg::iol_req_type b[$];
        for (int j = 0; j < 8; j++) begin
          b = {beat(iol_pkg::K_RD, 5'h2, 1'h0, 4'hb, 64'h0, 8'(64 + j))};
          u_req.send_pkt(b);
        end
      end
    join_none
    repeat (30) @(negedge mclk);
    chk("full", 64'h0, 64'(req_ready));
    hold_rsp <= 1'h0;
    for (int j = 0; j < 8; j++) begin
      take(r);
      chk("order", 64'(64 + j), 64'(r.tid));
      chk("drain", dw_a, r.data);
    end
    wait fork;
    // Reset in mid-run drops a pending answer
    hold_rsp <= 1'h1;
    pk = {beat(iol_pkg::K_RD, 5'h2, 1'h0, 4'hb, 64'h0, 8'h50)};
    u_req.send_pkt(pk);
    repeat (6) @(negedge mclk);
    reset = 1'h1;
    @(negedge mclk);
    chk("reset ready", 64'h1, 64'(req_ready));
    chk("reset valid", 64'h0, 64'(rsp_valid));
    chk("reset data", 64'h0, rsp.data);
    reset = 1'h0;
    hold_rsp <= 1'h0;
    repeat (8) @(posedge mclk);
    chk("after reset", 64'h0, 64'(u_req.got.size()));
    complete_run();
  end
endmodule : tb
